// ### hw/ptt_timer.sv
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ns
// Function
// [R1] 16-bit up-counter, free-running or modulo
// [R2] counter reads never disturb counting
// [R3] match with wrap value rolls to zero, flags
// [R4] flag clears after read-then-write-zero sequence
// [R5] overflow between read and write blocks clear
// [R6] writing one to flag ignored; reset clears
// [R7] irq while flag and enable; enable resets low
// [R8] halt bit holds counter; resets set
// [R9] clear bit zeroes counter, prescaler; reads zero
// [R10] halt plus clear leaves counter at zero
// [R11] prescale select divides by 1..64
// [R12] high read latches low byte until read
// [R13] reset and clear bit zero counter registers
// [R14] wait mode keeps counting; registers inaccessible
// [R15] stop mode freezes timer, keeps state
// [R16] break halts the counter
// [R17] break without clear enable protects flag
// [R18] break with clear enable allows clearing
// [R19] software unlatches low byte before break exit
// [R20] counter restarts at zero after wrap value
// [R21] wrap high write suppresses flag until low
// [R22] software clears counter before wrap writes
// [R23] count advances on each enabled prescaler tick
module ptt_timer
  import ptt_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic wait_mode,
  input wire logic stop_mode,
  input wire logic break_state,
  input wire logic break_clear_enable,
  output logic irq_request
);

  // mode pins come from the system controller; sync them first
  logic [1:0] wait_sync;
  logic [1:0] stop_sync;
  logic [1:0] brk_sync;
  logic [1:0] bce_sync;
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      wait_sync <= 2'h0;
      stop_sync <= 2'h0;
      brk_sync <= 2'h0;
      bce_sync <= 2'h0;
    end
    else
    begin
      wait_sync <= {wait_sync[0], wait_mode};
      stop_sync <= {stop_sync[0], stop_mode};
      brk_sync <= {brk_sync[0], break_state};
      bce_sync <= {bce_sync[0], break_clear_enable};
    end
  end
  logic in_wait;
  logic in_stop;
  logic in_break;
  logic bce;
  assign in_wait = wait_sync[1];
  assign in_stop = stop_sync[1];
  assign in_break = brk_sync[1];
  assign bce = bce_sync[1];

  // decode a byte address into a register select
  function automatic ptt_sel_s decode(input logic [31:0] addr);
    ptt_sel_s s;
    s = '0;
    if (addr == {22'h0, IDX_STATUS_CONTROL, 2'h0})
      s.status_control = 1'b1;
    else if (addr == {22'h0, IDX_COUNT_HIGH, 2'h0})
      s.count_high = 1'b1;
    else if (addr == {22'h0, IDX_COUNT_LOW, 2'h0})
      s.count_low = 1'b1;
    else if (addr == {22'h0, IDX_WRAP_HIGH, 2'h0})
      s.wrap_high = 1'b1;
    else if (addr == {22'h0, IDX_WRAP_LOW, 2'h0})
      s.wrap_low = 1'b1;
    return s;
  endfunction

  // address phase capture; zero wait states
  ptt_sel_s dsel;
  logic dwrite;
  logic dvalid;
  logic addr_take;
  assign addr_take = hsel && hready && (htrans == HTRANS_NONSEQ);
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      dsel <= '0;
      dwrite <= 1'b0;
      dvalid <= 1'b0;
    end
    else
    begin
      // [R14] wait mode drops access: cpu cannot reach registers
      dvalid <= addr_take && !in_wait;
      dsel <= decode(haddr);
      dwrite <= hwrite;
    end
  end
  // hready always high, response always okay
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // read strobes at address phase so data is ready next cycle
  ptt_sel_s asel;
  logic rd_take;
  assign asel = decode(haddr);
  assign rd_take = addr_take && !hwrite && !in_wait;
  logic wr_sc;
  logic wr_wh;
  logic wr_wl;
  logic [7:0] wb;
  assign wb = hwdata[7:0];
  assign wr_sc = dvalid && dwrite && dsel.status_control;
  assign wr_wh = dvalid && dwrite && dsel.wrap_high;
  assign wr_wl = dvalid && dwrite && dsel.wrap_low;

  // control fields
  logic ovf;
  logic irq_en;
  logic halt;
  logic [2:0] presel;
  logic [15:0] count;
  logic [15:0] wrap;
  logic [5:0] prescale;
  logic ovf_armed;
  logic wrap_hold;
  logic [7:0] low_latch;
  logic low_latched;
  logic clear_pulse;

  // control bits: enable, halt and prescale select
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      // [R7] enable resets low
      irq_en <= 1'b0;
      // [R8] halt set at reset
      halt <= 1'b1;
      // [R11] select cleared by reset
      presel <= PRESEL_RESET;
    end
    else if (wr_sc)
    begin
      irq_en <= wb[BIT_IRQ_EN];
      halt <= wb[BIT_HALT];
      presel <= wb[PRESEL_LSB +: 3];
    end
  end

  // [R9] clear bit is a one-cycle pulse, never stored
  assign clear_pulse = wr_sc && wb[BIT_CLEAR];

  // prescaler tick for the selected divide ratio
  function automatic logic tick_of(input logic [2:0] sel, input logic [5:0] pre);
    logic [5:0] mask;
    mask = 6'h0;
    case (sel)
      3'h0: mask = 6'h00;
      3'h1: mask = 6'h01;
      3'h2: mask = 6'h03;
      3'h3: mask = 6'h07;
      3'h4: mask = 6'h0F;
      3'h5: mask = 6'h1F;
      default: mask = PRESCALE_MAX;
    endcase
    return (pre & mask) == mask;
  endfunction

  logic run;
  logic tick;
  logic match;
  // [R23] count only with halt clear and no break or stop
  // [R16] break halts counting
  // [R15] stop mode freezes prescaler and counter but keeps state
  assign run = !halt && !in_break && !in_stop;
  // [R11] selected prescaler output
  assign tick = run && tick_of(presel, prescale);
  assign match = (count == wrap);

  // prescaler and counter
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      prescale <= 6'h00;
      // [R13] counter registers zero after reset
      count <= COUNT_RESET;
    end
    else if (clear_pulse)
    begin
      // [R10] clear wins, halt only keeps it at zero
      prescale <= 6'h00;
      count <= COUNT_RESET;
    end
    else if (run)
    begin
      prescale <= prescale + 6'h01;
      // [R14] wait mode does not stop counting
      if (tick)
      begin
        // [R3] [R20] roll to zero after wrap value
        if (match)
          count <= COUNT_RESET;
        else
          // [R1] up-count
          count <= count + 16'h0001;
      end
    end
  end

  logic ovf_event;
  // [R21] rollover flags only when wrap pair is complete
  assign ovf_event = tick && match && !wrap_hold;

  // wrap registers with high-byte hold
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      // [R21] wrap resets to all ones
      wrap <= WRAP_RESET;
      wrap_hold <= 1'b0;
    end
    else if (wr_wh)
    begin
      wrap[15:8] <= wb;
      wrap_hold <= 1'b1;
    end
    else if (wr_wl)
    begin
      wrap[7:0] <= wb;
      wrap_hold <= 1'b0;
    end
  end

  // status protection during break when clearing is not enabled
  logic protect;
  assign protect = in_break && !bce;

  // overflow flag with read-arm clearing sequence
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      // [R6] reset clears flag
      ovf <= 1'b0;
      ovf_armed <= 1'b0;
    end
    else if (ovf_event)
    begin
      // [R5] new overflow cancels a pending clear; set wins
      ovf <= 1'b1;
      ovf_armed <= 1'b0;
    end
    else
    begin
      // [R17] first step not taken while protected
      if (rd_take && asel.status_control && ovf && !protect)
        ovf_armed <= 1'b1;
      // [R4] write of zero after armed read clears
      // [R6] writing one changes nothing
      // [R18] clearing allowed in break when enabled
      if (wr_sc && !wb[BIT_OVF] && ovf_armed && !protect)
      begin
        ovf <= 1'b0;
        ovf_armed <= 1'b0;
      end
    end
  end

  // counter low-byte latch on high-byte read
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      low_latch <= 8'h00;
      low_latched <= 1'b0;
    end
    else if (rd_take && asel.count_high && !low_latched)
    begin
      // [R12] capture low byte on first high read
      low_latch <= count[7:0];
      low_latched <= 1'b1;
    end
    else if (rd_take && asel.count_low)
      // [R19] reading low byte releases the latch
      low_latched <= 1'b0;
  end

  // read data, registered at address phase
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      hrdata <= 32'h0000_0000;
    else if (rd_take)
    begin
      // [R2] reads only sample, never touch the counter
      if (asel.status_control)
        hrdata <= {24'h0, ovf, irq_en, halt, 2'h0, presel};
      else if (asel.count_high)
        hrdata <= {24'h0, count[15:8]};
      else if (asel.count_low)
        hrdata <= {24'h0, low_latched ? low_latch : count[7:0]};
      else if (asel.wrap_high)
        hrdata <= {24'h0, wrap[15:8]};
      else if (asel.wrap_low)
        hrdata <= {24'h0, wrap[7:0]};
      else
        hrdata <= 32'h0000_0000;
    end
    else
      hrdata <= 32'h0000_0000;
  end

  // interrupt request, registered
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      irq_request <= 1'b0;
    else
      // [R7] request while flag and enable
      irq_request <= ovf && irq_en;
  end

  // assertions
  halt_holds_a: assert property (@(posedge mclk) disable iff (!rstn) // [R8]
    (halt && !clear_pulse) |=> $stable(count))
    else $error("count moved while halted");
  clear_zero_a: assert property (@(posedge mclk) disable iff (!rstn) // [R9]
    clear_pulse |=> (count == 16'h0000 && prescale == 6'h00))
    else $error("clear did not zero counter");
  wrap_roll_a: assert property (@(posedge mclk) disable iff (!rstn) // [R3]
    (tick && match && !clear_pulse) |=> (count == 16'h0000))
    else $error("no rollover at wrap value");
  flag_set_a: assert property (@(posedge mclk) disable iff (!rstn) // [R5]
    ovf_event |=> ovf)
    else $error("overflow flag not set");
  irq_follow_a: assert property (@(posedge mclk) disable iff (!rstn) // [R7]
    (ovf && irq_en) |=> irq_request)
    else $error("irq missing");
  break_stop_a: assert property (@(posedge mclk) disable iff (!rstn) // [R16]
    (in_break && !clear_pulse) |=> $stable(count))
    else $error("counted during break");
  protect_flag_a: assert property (@(posedge mclk) disable iff (!rstn) // [R17]
    (protect && ovf) |=> ovf)
    else $error("flag cleared while protected");
  unarmed_keep_a: assert property (@(posedge mclk) disable iff (!rstn) // [R4]
    (ovf && !ovf_armed) |=> ovf)
    else $error("flag cleared without read");
  hold_noflag_a: assert property (@(posedge mclk) disable iff (!rstn) // [R21]
    wrap_hold |=> !$rose(ovf))
    else $error("flag set with wrap pair open");
  latch_keep_a: assert property (@(posedge mclk) disable iff (!rstn) // [R12]
    (low_latched && !(rd_take && asel.count_low)) |=> $stable(low_latch))
    else $error("latched low byte changed");
  tick_step_a: assert property (@(posedge mclk) disable iff (!rstn) // [R23]
    (tick && !match && !clear_pulse) |=> count == $past(count) + 16'h0001)
    else $error("count did not step");

  rollover_c: cover property (@(posedge mclk) disable iff (!rstn) ovf_event);
  clear_seq_c: cover property (@(posedge mclk) disable iff (!rstn) $fell(ovf));
  latch_c: cover property (@(posedge mclk) disable iff (!rstn) $rose(low_latched));
  irq_c: cover property (@(posedge mclk) disable iff (!rstn) $rose(irq_request));

endmodule // ptt_timer

// ### hw/ptt_pkg.sv
package ptt_pkg;
  // register offsets: printed offsets are not all multiples of four, so each is an index
  localparam logic [7:0] IDX_STATUS_CONTROL = 8'h4B;
  localparam logic [7:0] IDX_COUNT_HIGH = 8'h4C;
  localparam logic [7:0] IDX_COUNT_LOW = 8'h4D;
  localparam logic [7:0] IDX_WRAP_HIGH = 8'h4E;
  localparam logic [7:0] IDX_WRAP_LOW = 8'h4F;
  // status/control bit positions
  localparam int BIT_OVF = 7;
  localparam int BIT_IRQ_EN = 6;
  localparam int BIT_HALT = 5;
  localparam int BIT_CLEAR = 4;
  localparam int PRESEL_LSB = 0;
  // reset values
  localparam logic [15:0] WRAP_RESET = 16'hFFFF;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [2:0] PRESEL_RESET = 3'h0;
  localparam logic [5:0] PRESCALE_MAX = 6'h3F;
  // ahb htrans codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  // decoded register access, one-hot per register
  typedef struct packed {
    logic status_control;
    logic count_high;
    logic count_low;
    logic wrap_high;
    logic wrap_low;
  } ptt_sel_s;
endpackage

// ### verif/test_periodic_interrupt_timer.sv
`timescale 1ns/1ns
module test_periodic_interrupt_timer
  import ptt_pkg::*;
;
  // short names for the register places
  localparam logic [7:0] SC = IDX_STATUS_CONTROL;
  localparam logic [7:0] CH = IDX_COUNT_HIGH;
  localparam logic [7:0] CL = IDX_COUNT_LOW;
  localparam logic [7:0] WH = IDX_WRAP_HIGH;
  localparam logic [7:0] WL = IDX_WRAP_LOW;
  logic mclk, rstn, hsel, hwrite, hreadyout, hresp, irq_request;
  logic wait_mode, stop_mode, break_state, break_clear_enable;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, lfsr, a, b, c;
  // expected reset contents; the last place is unmapped
  logic [7:0] rst_exp [6] = '{8'h20, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00};
  int err_count, comparisons, cyc, w, s, m, div;

  ptt_timer u_dut (.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .wait_mode(wait_mode), .stop_mode(stop_mode),
    .break_state(break_state), .break_clear_enable(break_clear_enable), .irq_request(irq_request));

  // bus clock, 4 ns period
  initial mclk = 1'b0;
  always #2 mclk = ~mclk;

  // cycle count: alignment of reads and the hang limit
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc >= 12000)
    begin
      err_count = err_count + 1;
      end_sim();
    end
  end

  // pseudo-random source, fixed start
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic end_sim();
    if (err_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one single word transfer; the wait is on hready, never a fixed count
  task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= wr;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rd = hrdata;
    chk("response", 32'h0, {31'h0, hresp});
  endtask

  // wait for a cycle count that is a multiple of n, so read gaps are exact
  task automatic align(input int n);
    do @(posedge mclk); while (cyc % n != 0);
  endtask

  initial
  begin
    {rstn, hsel, hwrite, wait_mode, stop_mode, break_state, break_clear_enable} = '0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = '0;
    hwdata = '0;
    err_count = 0;
    comparisons = 0;
    cyc = 0;
    lfsr = 32'h28A68772;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    // random writes to a read-only and an unmapped place must leave no trace
    lfsr = lfsr_next(lfsr);
    bus(CH, 1'b1, lfsr[7:0], a);
    bus(8'h50, 1'b1, lfsr[15:8], a);
    for (m = 0; m < 6; m++)
    begin
      bus(8'(SC + m), 1'b0, 8'h00, a);
      chk("reset value", {24'h0, rst_exp[m]}, a);
    end
    chk("irq at reset", 32'h0, {31'h0, irq_request});
    // every select code; 128 cycles between reads give the division
    for (s = 0; s < 8; s++)
    begin
      bus(SC, 1'b1, 8'h30, a);
      bus(SC, 1'b1, 8'(s), a);
      align(128);
      bus(CL, 1'b0, 8'h00, a);
      align(128);
      bus(CL, 1'b0, 8'h00, b);
      div = 1 << ((s == 7) ? 6 : s);
      chk("prescale delta", 32'((a + 128 / div) % 256), b);
    end
    // halt and clear together from a running count
    bus(SC, 1'b1, 8'h37, a);
    repeat (20) @(posedge mclk);
    bus(CH, 1'b0, 8'h00, a);
    chk("cleared count high", 32'h0, a);
    bus(CL, 1'b0, 8'h00, a);
    chk("cleared count", 32'h0, a);
    bus(SC, 1'b0, 8'h00, a);
    chk("clear bit reads zero", 32'h27, a);
    // counter cleared before the wrap writes
    // random even wrap value
    lfsr = lfsr_next(lfsr);
    w = 8 + 2 * (lfsr % 28);
    bus(WH, 1'b1, 8'h00, a);
    bus(WL, 1'b1, 8'(w), a);
    bus(SC, 1'b1, 8'h40, a);
    align(64);
    bus(CL, 1'b0, 8'h00, a);
    align(64);
    bus(CL, 1'b0, 8'h00, b);
    chk("wrap count", 32'((a + 64) % (w + 1)), b);
    // odd period, so a missing latch gives a different low byte
    align(64);
    bus(CH, 1'b0, 8'h00, a);
    chk("count high", 32'h0, a);
    align(64);
    bus(CH, 1'b0, 8'h00, a);
    align(64);
    bus(CL, 1'b0, 8'h00, a);
    align(64);
    bus(CL, 1'b0, 8'h00, b);
    chk("latched low", 32'((a + 192) % (w + 1)), b);
    bus(SC, 1'b0, 8'h00, a);
    chk("flag set", 32'hC0, a);
    chk("irq raised", 32'h1, {31'h0, irq_request});
    // a full period passes between the read and the write of zero
    repeat (w + 1) @(posedge mclk);
    bus(SC, 1'b1, 8'h40, a);
    bus(SC, 1'b0, 8'h00, a);
    chk("flag kept", 32'hC0, a);
    // halt with a one in the flag bit, which must not touch the flag
    bus(SC, 1'b1, 8'hE0, a);
    bus(SC, 1'b0, 8'h00, a);
    chk("flag before clear", 32'hE0, a);
    bus(SC, 1'b1, 8'h60, a);
    bus(SC, 1'b0, 8'h00, a);
    chk("flag cleared", 32'h60, a);
    chk("irq dropped", 32'h0, {31'h0, irq_request});
    bus(SC, 1'b1, 8'hE0, a);
    bus(SC, 1'b0, 8'h00, a);
    chk("flag write one", 32'h60, a);
    // wrap high alone holds the flag off until wrap low is written
    bus(SC, 1'b1, 8'h70, a);
    bus(WH, 1'b1, 8'h00, a);
    bus(SC, 1'b1, 8'h40, a);
    repeat (3 * w) @(posedge mclk);
    bus(SC, 1'b0, 8'h00, a);
    chk("flag held off", 32'h40, a);
    bus(WL, 1'b1, 8'(w), a);
    repeat (2 * w + 4) @(posedge mclk);
    bus(SC, 1'b0, 8'h00, a);
    chk("flag after low", 32'hC0, a);
    // wait, stop, break in turn
    for (m = 0; m < 3; m++)
    begin
      align(64);
      bus(CL, 1'b0, 8'h00, a);
      {break_state, stop_mode, wait_mode} <= 3'(1 << m);
      repeat (8) @(posedge mclk);
      bus(CL, 1'b0, 8'h00, c);
      align(64);
      bus(CL, 1'b0, 8'h00, b);
      {break_state, stop_mode, wait_mode} <= 3'h0;
      if (m == 0)
      begin
        chk("wait read", 32'h0, c | b);
        align(64);
        bus(CL, 1'b0, 8'h00, b);
        chk("wait counting", 32'((a + 128) % (w + 1)), b);
      end
      else
        chk("frozen count", c, b);
      repeat (8) @(posedge mclk);
    end
    // flag protection in break, then clearing allowed
    break_state <= 1'b1;
    repeat (8) @(posedge mclk);
    bus(SC, 1'b0, 8'h00, a);
    bus(SC, 1'b1, 8'h40, a);
    bus(SC, 1'b0, 8'h00, a);
    chk("break protects", 32'hC0, a);
    // high read in break, low read unlatches before exit
    bus(CH, 1'b0, 8'h00, a);
    chk("count high in break", 32'h0, a);
    bus(CL, 1'b0, 8'h00, a);
    break_clear_enable <= 1'b1;
    repeat (4) @(posedge mclk);
    // both clearing steps inside the break; halt so no new overflow follows
    bus(SC, 1'b0, 8'h00, a);
    bus(SC, 1'b1, 8'h60, a);
    bus(SC, 1'b0, 8'h00, a);
    chk("break clears", 32'h60, a);
    chk("irq after clear", 32'h0, {31'h0, irq_request});
    break_state <= 1'b0;
    repeat (4) @(posedge mclk);
    bus(SC, 1'b0, 8'h00, a);
    chk("clear kept after break", 32'h60, a);
    // first step before break, second only counts after it
    break_clear_enable <= 1'b0;
    bus(SC, 1'b1, 8'h40, a);
    repeat (w + 4) @(posedge mclk);
    bus(SC, 1'b1, 8'hE0, a);
    bus(SC, 1'b0, 8'h00, a);
    chk("flag before break", 32'hE0, a);
    break_state <= 1'b1;
    repeat (4) @(posedge mclk);
    bus(SC, 1'b1, 8'h60, a);
    bus(SC, 1'b0, 8'h00, a);
    chk("second step in break", 32'hE0, a);
    break_state <= 1'b0;
    repeat (4) @(posedge mclk);
    bus(SC, 1'b1, 8'h60, a);
    bus(SC, 1'b0, 8'h00, a);
    chk("second step after break", 32'h60, a);
    end_sim();
  end
endmodule // test_periodic_interrupt_timer
